//--- hw/self_wakeup_timer.v
// self wake-up timer: prescaled auto-reload up-counter on a slow clock
//
// Notes on behaviour
// - keeps counting in idle and power-down
// - count clock from rc oscillator or crystal
// - system clock at least twice count clock
// - selected source kept on while running
// - configuration never enables the oscillator itself
// - prescaled auto-reload up-counter, 1/1 to 1/2048
// - writable reload value sets overflow rate
// - rollover from ffh sets flag, reloads
// - current count is readable live
// - run bit starts counting, clear holds
// - interrupt when enabled and flag set
`timescale 1ns/1ps
`include "wake_timer_consts.vh"
module self_wakeup_timer (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire low_speed_rc_osc_i,
   input wire low_speed_crystal_i,
   input wire clk_sel_crystal_i,
   input wire idle_mode_i,
   input wire power_down_i,
   input wire wake_run_i,
   input wire [2:0] wake_prescale_sel_i,
   input wire [7:0] wake_reload_value_i,
   input wire wake_reload_we_i,
   input wire wake_flag_clear_i,
   input wire wake_irq_enable_i,
   output wire [7:0] wake_current_count_o,
   output wire [7:0] wake_reload_value_o,
   output wire wake_overflow_flag_o,
   output wire wake_irq_o,
   output wire wake_wakeup_o,
   output wire rc_osc_keep_on_o,
   output wire crystal_keep_on_o
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg [`WAKE_CNT_W-1:0] count_r;
   reg [`WAKE_CNT_W-1:0] count_nxt;
   reg [`WAKE_CNT_W-1:0] reload_r;
   reg [`WAKE_DIV_W-1:0] div_r;
   reg [`WAKE_DIV_W-1:0] div_nxt;
   reg flag_r;
   reg flag_nxt;
   reg ovf_pulse_r;
   reg tick;
   wire sel_clk;
   wire slow_rise;
   wire ps_done;

   // divide ratio minus one for each prescale code
   function [`WAKE_DIV_W-1:0] div_limit;
      input [`WAKE_PS_W-1:0] sel;
      begin
         case (sel)
            3'h0: div_limit = `WAKE_DIV_LIM0;
            3'h1: div_limit = `WAKE_DIV_LIM1;
            3'h2: div_limit = `WAKE_DIV_LIM2;
            3'h3: div_limit = `WAKE_DIV_LIM3;
            3'h4: div_limit = `WAKE_DIV_LIM4;
            3'h5: div_limit = `WAKE_DIV_LIM5;
            3'h6: div_limit = `WAKE_DIV_LIM6;
            default: div_limit = `WAKE_DIV_LIM7;
         endcase
      end
   endfunction

   // counter sits at its rollover value
   function at_top;
      input [`WAKE_CNT_W-1:0] val;
      begin
         at_top = (val == `WAKE_CNT_TOP);
      end
   endfunction

   // ------------------------------------------------------------
   // count clock selection and sampling
   // ------------------------------------------------------------
   // oscillator enable is left to the clock controller; we only request it kept on
   assign sel_clk = clk_sel_crystal_i ? low_speed_crystal_i : low_speed_rc_osc_i;

   // sampling assumes the system clock is at least twice the count clock
   wake_clk_sync u_sync (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .async_i(sel_clk),
      .rise_o(slow_rise)
   );

   // ------------------------------------------------------------
   // prescaler
   // ------------------------------------------------------------
   assign ps_done = (div_r >= div_limit(wake_prescale_sel_i));

   always @* begin
      div_nxt = div_r;
      tick = 1'b0;
      if (!wake_run_i) begin
         div_nxt = `WAKE_DIV_RST;
      end else if (slow_rise) begin
         if (ps_done) begin
            div_nxt = `WAKE_DIV_RST;
            tick = 1'b1;
         end else begin
            div_nxt = div_r + 11'h001;
         end
      end
   end

   // ------------------------------------------------------------
   // counter, reload and flag
   // ------------------------------------------------------------
   // low power mode inputs do not gate the counter
   always @* begin
      count_nxt = count_r;
      flag_nxt = flag_r;
      if (wake_flag_clear_i) begin
         flag_nxt = 1'b0;
      end
      if (tick) begin
         if (at_top(count_r)) begin
            count_nxt = reload_r;
            flag_nxt = 1'b1;
         end else begin
            count_nxt = count_r + 8'h01;
         end
      end
   end

   always @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         count_r <= `WAKE_CNT_RST;
         reload_r <= `WAKE_RELOAD_RST;
         div_r <= `WAKE_DIV_RST;
         flag_r <= 1'b0;
         ovf_pulse_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         div_r <= div_nxt;
         flag_r <= flag_nxt;
         ovf_pulse_r <= tick & at_top(count_r);
         if (wake_reload_we_i) begin
            reload_r <= wake_reload_value_i;
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign wake_current_count_o = count_r;
   assign wake_reload_value_o = reload_r;
   assign wake_overflow_flag_o = flag_r;
   assign wake_irq_o = flag_r & wake_irq_enable_i;
   assign wake_wakeup_o = ovf_pulse_r & (idle_mode_i | power_down_i);
   assign rc_osc_keep_on_o = wake_run_i & ~clk_sel_crystal_i;
   assign crystal_keep_on_o = wake_run_i & clk_sel_crystal_i;
endmodule

//--- hw/wake_clk_sync.v
// two-stage synchroniser with rising edge detect for the slow count clock
`timescale 1ns/1ps
module wake_clk_sync (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire async_i,
   output wire rise_o
);
   reg meta_r;
   reg sync_r;
   reg last_r;

   always @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign rise_o = sync_r & ~last_r;
endmodule

//--- hw/wake_timer_consts.vh
// constants for the self wake-up timer
`ifndef WAKE_TIMER_CONSTS_VH
`define WAKE_TIMER_CONSTS_VH

`define WAKE_CNT_W 8
`define WAKE_PS_W 3
`define WAKE_DIV_W 11
`define WAKE_CNT_RST 8'h00
`define WAKE_RELOAD_RST 8'h00
`define WAKE_PS_RST 3'h0
`define WAKE_DIV_RST 11'h000
`define WAKE_CNT_TOP 8'hff
`define WAKE_DIV_LIM0 11'h000
`define WAKE_DIV_LIM1 11'h003
`define WAKE_DIV_LIM2 11'h00f
`define WAKE_DIV_LIM3 11'h01f
`define WAKE_DIV_LIM4 11'h03f
`define WAKE_DIV_LIM5 11'h0ff
`define WAKE_DIV_LIM6 11'h3ff
`define WAKE_DIV_LIM7 11'h7ff
`define WAKE_RC_HZ 38400
`define WAKE_XTAL_HZ 32768
`define WAKE_SYS_HZ 40000000

`endif

//--- test/tb_self_wakeup_timer.sv
// self-checking testbench for the self wake-up timer
`timescale 1ns/1ps
module tb_self_wakeup_timer;
   reg clk = 1'b0, rst_n = 1'b0, rc = 1'b0, xt = 1'b0, xs = 1'b0, idle = 1'b0, pd = 1'b0, run = 1'b0;
   reg [2:0] ps = 3'h0;
   reg [7:0] rv = 8'h00;
   reg we = 1'b0, clr = 1'b0, en = 1'b0;
   wire [7:0] cnt, rvo;
   wire flag, irq, wk, rko, xko;
   reg wk_seen = 1'b0;
   integer err_total = 0, compares = 0;
   self_wakeup_timer i_self_wakeup_timer (.sys_clk_i(clk), .resetn_i(rst_n),
      .low_speed_rc_osc_i(rc), .low_speed_crystal_i(xt), .clk_sel_crystal_i(xs),
      .idle_mode_i(idle), .power_down_i(pd), .wake_run_i(run), .wake_prescale_sel_i(ps),
      .wake_reload_value_i(rv), .wake_reload_we_i(we), .wake_flag_clear_i(clr),
      .wake_irq_enable_i(en), .wake_current_count_o(cnt), .wake_reload_value_o(rvo),
      .wake_overflow_flag_o(flag), .wake_irq_o(irq), .wake_wakeup_o(wk),
      .rc_osc_keep_on_o(rko), .crystal_keep_on_o(xko));
   initial begin
      forever #12.5 clk = ~clk;
   end
   // the wake pulse lasts one cycle, so latch it for the scenario to judge
   always @(posedge clk) begin
      if (wk === 1'b1) wk_seen <= 1'b1;
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // slow pulses on the selected source only
   task pul(input integer n);
      repeat (n) begin
         rc <= !xs;
         xt <= xs;
         repeat (4) @(posedge clk);
         rc <= 1'b0;
         xt <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   task t_run;
      run <= 1'b1;
      pul(5);
      chk(cnt, 8'h05);
      run <= 1'b0;
      pul(3);
      chk(cnt, 8'h05);
      $display("test run/hold done");
   endtask
   task t_wrap;
      rv <= 8'hf0;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      @(posedge clk);
      chk(rvo, 8'hf0);
      idle <= 1'b1;
      en <= 1'b1;
      run <= 1'b1;
      pul(250);
      chk(cnt, 8'hff);
      chk({7'h00, wk_seen}, 8'h00);
      chk({6'h00, rko, xko}, 8'h02);
      pul(1);
      chk(cnt, 8'hf0);
      chk({7'h00, irq}, 8'h01);
      chk({7'h00, wk_seen}, 8'h01);
      $display("test wrap done");
   endtask
   task t_clear_xtal;
      pd <= 1'b1;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      @(posedge clk);
      chk({7'h00, flag}, 8'h00);
      xs <= 1'b1;
      ps <= 3'h2;
      @(posedge clk);
      pul(32);
      chk(cnt, 8'hf2);
      chk({6'h00, rko, xko}, 8'h01);
      $display("test clear/crystal done");
   endtask
   task t_reset;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(cnt, 8'h00);
      chk(rvo, 8'h00);
      chk({7'h00, flag}, 8'h00);
      $display("test mid-run reset done");
   endtask
   task end_of_test;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_run;
      t_wrap;
      t_clear_xtal;
      t_reset;
      end_of_test;
   end
   initial begin
      repeat (6000) @(posedge clk);
      err_total = err_total + 1;
      end_of_test;
   end
endmodule

//--- test/wake_timer_monitor.sv
// assertion checker for the self wake-up timer ports
`timescale 1ns/1ps
module wake_timer_monitor (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire wake_run_i,
   input wire clk_sel_crystal_i,
   input wire idle_mode_i,
   input wire power_down_i,
   input wire wake_reload_we_i,
   input wire [7:0] wake_reload_value_i,
   input wire wake_flag_clear_i,
   input wire wake_irq_enable_i,
   input wire [7:0] wake_current_count_o,
   input wire [7:0] wake_reload_value_o,
   input wire wake_overflow_flag_o,
   input wire wake_irq_o,
   input wire wake_wakeup_o,
   input wire rc_osc_keep_on_o,
   input wire crystal_keep_on_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   chk_irq_level: assert property (wake_irq_o == (wake_overflow_flag_o && wake_irq_enable_i))
      else $error("irq differs from flag and enable");
   chk_keep_rc: assert property (rc_osc_keep_on_o == (wake_run_i && !clk_sel_crystal_i))
      else $error("rc keep-on wrong");
   chk_keep_xtal: assert property (crystal_keep_on_o == (wake_run_i && clk_sel_crystal_i))
      else $error("crystal keep-on wrong");
   chk_flag_sticky: assert property (wake_overflow_flag_o && !wake_flag_clear_i |=> wake_overflow_flag_o)
      else $error("flag dropped without clear");
   chk_reload_write: assert property (wake_reload_we_i |=> wake_reload_value_o == $past(wake_reload_value_i))
      else $error("reload write lost");
   chk_run_hold: assert property (!wake_run_i |=> $stable(wake_current_count_o))
      else $error("count moved while stopped");
   chk_count_step: assert property ($changed(wake_current_count_o) && $past(wake_current_count_o) != 8'hff |-> wake_current_count_o == $past(wake_current_count_o) + 8'h01)
      else $error("count step not one");
   chk_wrap_load: assert property ($changed(wake_current_count_o) && $past(wake_current_count_o) == 8'hff |-> wake_overflow_flag_o && wake_current_count_o == wake_reload_value_o)
      else $error("rollover did not reload and flag");
   chk_wake_mode: assert property (wake_wakeup_o |-> wake_overflow_flag_o && (idle_mode_i || power_down_i))
      else $error("wakeup outside low power");
endmodule
bind self_wakeup_timer wake_timer_monitor i_wake_timer_monitor (.*);
